/* File: hw/sds_pkg.sv */
// package: register map, field layout and types of the sine pattern dac sequencer
package sds_pkg;
  // ==========================================================================
  // bus geometry
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned DATA_W        = 32;
  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] OFS_GEN_CTRL  = 12'h000;
  localparam logic [11:0] OFS_CLK_DIV   = 12'h004;
  localparam logic [11:0] OFS_HALF_CNT  = 12'h008;
  localparam logic [11:0] OFS_AMP_CTRL  = 12'h00C;
  localparam logic [11:0] OFS_SW_CTRL   = 12'h010;
  localparam logic [11:0] OFS_REF_DAC   = 12'h014;
  localparam logic [11:0] OFS_FILT_CTRL = 12'h018;
  // pattern window: ram byte 80H+i sits at word PAT_BASE + 4*i
  localparam logic [11:0] PAT_BASE      = 12'h200;
  localparam logic [11:0] PAT_LAST      = 12'h2FC;
  localparam int unsigned PAT_ENTRIES   = 32;
  localparam int unsigned PAT_W         = 9;
  // ==========================================================================
  // field positions
  localparam int unsigned GEN_EN_BIT    = 7;
  localparam int unsigned BIAS_EN_BIT   = 4;
  localparam int unsigned AMP_EN_BIT    = 7;
  localparam int unsigned FILT_EN_BIT   = 7;
  localparam int unsigned HYST_EN_BIT   = 4;
  localparam int unsigned DIS_B_BIT     = 1;
  localparam int unsigned DIS_A_BIT     = 0;
  // writable bits of each 8-bit register
  localparam logic [7:0]  MASK_GEN_CTRL = 8'h90;
  localparam logic [7:0]  MASK_CLK_DIV  = 8'h3F;
  localparam logic [7:0]  MASK_HALF_CNT = 8'h1F;
  localparam logic [7:0]  MASK_AMP_CTRL = 8'h8F;
  localparam logic [7:0]  MASK_SW_CTRL  = 8'hFF;
  localparam logic [7:0]  MASK_REF_DAC  = 8'h3F;
  localparam logic [7:0]  MASK_FILT     = 8'h93;
  // ==========================================================================
  // reset values and codes
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [9:0]  DAC_MID       = 10'h200;
  localparam logic [3:0]  GAIN_MAX_CODE = 4'hA;
  localparam logic [3:0]  GAIN_UNITY    = 4'h0;
  // ==========================================================================
  // types
  typedef enum logic {SEQ_IDLE, SEQ_RUN} sds_seq_e;
  // analog control bundle toward the front end
  typedef struct packed {
    logic       gen_power;
    logic       bias_divider_enable;
    logic       amplifier_enable;
    logic       ref_dac_power;
    logic [3:0] diff_gain_select;
    logic [7:0] measure_switch_n;
    logic [5:0] ref_dac_code;
    logic       filter_enable;
    logic       hysteresis_enable;
    logic       discharge_switch_a;
    logic       discharge_switch_b;
  } sds_analog_s;
endpackage

/* File: hw/sds_sequencer.sv */
// module: apb register file, pattern store and sine sequencer with dac feed
// Functional notes
// - one output period every M clocks
// - sample step every N clocks, DN per period
// - pattern store holds 32 nine-bit samples
// - pattern window is ram bytes 80H to BFH
// - even byte bits 7:0, odd byte bit 8
// - cpu access to window blocked while running
// - samples fetched in order to 10-bit dac
// - enable bit 7; off powers down dac, buffer
// - bit 4 powers bias divider
// - divider N is bits 5:0 plus one
// - half count is bits 4:0 plus one
// - unimplemented bits read zero, ignore writes
// - amp enable off powers down amps, reference dac
// - gain codes 1..10 valid, others unity
// - switch bit n closes switch n
// - reference dac code in bits 5:0
// - filter bits 7, 4, discharge bits 1, 0
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
module sds_sequencer
  import sds_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  // dac stream and analog controls
  output logic      [9:0]        dac_code,
  output logic                   period_start,
  output sds_analog_s            analog
);

  // ==========================================================================
  // decode helpers
  // true for a word inside the pattern window
  function automatic logic is_pattern(input logic [11:0] a);
    is_pattern = (a >= PAT_BASE) && (a <= PAT_LAST) && (a[1:0] == 2'b00);
  endfunction

  // true for one of the seven control words
  function automatic logic is_ctrl(input logic [11:0] a);
    is_ctrl = (a <= OFS_FILT_CTRL) && (a[1:0] == 2'b00);
  endfunction

  // only gain codes 1..10 pass, others fold to unity
  function automatic logic [3:0] gain_norm(input logic [3:0] c);
    gain_norm = ((c != GAIN_UNITY) && (c <= GAIN_MAX_CODE)) ? c : GAIN_UNITY;
  endfunction

  // ==========================================================================
  // registers and state
  logic [7:0]       gen_ctrl_r;
  logic [7:0]       clk_div_r;
  logic [7:0]       half_cnt_r;
  logic [7:0]       amp_ctrl_r;
  logic [7:0]       sw_ctrl_r;
  logic [7:0]       ref_dac_r;
  logic [7:0]       filt_ctrl_r;
  logic [PAT_W-1:0] pat_mem [PAT_ENTRIES];
  logic             pready_r;
  logic [31:0]      prdata_r;
  logic             pslverr_r;
  logic [31:0]      rd_nxt;
  logic             err_nxt;
  logic             setup;
  logic             wr_go;
  logic [5:0]       pat_idx;
  logic             gen_on;
  sds_seq_e         seq_r;
  logic [5:0]       div_cnt_r;
  logic [5:0]       sample_r;
  logic             tick;
  logic [5:0]       half_len;
  logic [5:0]       last_idx;
  logic [PAT_W-1:0] cur_pat;
  logic [9:0]       dac_r;
  logic [9:0]       dac_nxt;
  logic             period_r;
  logic [3:0]       gain_r;

  assign setup   = psel && !penable;
  assign wr_go   = psel && penable && pready_r && pwrite && !pslverr_r;
  assign pat_idx = 6'((paddr - PAT_BASE) >> 2);
  assign gen_on  = gen_ctrl_r[GEN_EN_BIT];

  // ==========================================================================
  // apb read path and error decision, sampled in the setup cycle
  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (is_ctrl(paddr)) begin
      case (paddr)
        OFS_GEN_CTRL:  rd_nxt[7:0] = gen_ctrl_r;
        OFS_CLK_DIV:   rd_nxt[7:0] = clk_div_r;
        OFS_HALF_CNT:  rd_nxt[7:0] = half_cnt_r;
        OFS_AMP_CTRL:  rd_nxt[7:0] = amp_ctrl_r;
        OFS_SW_CTRL:   rd_nxt[7:0] = sw_ctrl_r;
        OFS_REF_DAC:   rd_nxt[7:0] = ref_dac_r;
        OFS_FILT_CTRL: rd_nxt[7:0] = filt_ctrl_r;
        default:       rd_nxt      = 32'h0000_0000;
      endcase
    end else if (is_pattern(paddr)) begin
      if (gen_on) begin
        err_nxt = 1'b1;
      end else if (!pat_idx[0]) begin
        rd_nxt[7:0] = pat_mem[pat_idx[5:1]][7:0];
      end else begin
        rd_nxt[0] = pat_mem[pat_idx[5:1]][8];
      end
    end else begin
      err_nxt = 1'b1;
    end
  end

  // apb handshake: answer in the cycle after setup, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup ? err_nxt : 1'b0;
      prdata_r  <= (setup && !pwrite) ? rd_nxt : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // control register writes, unimplemented bits masked off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_ctrl_r  <= REG_RESET;
      clk_div_r   <= REG_RESET;
      half_cnt_r  <= REG_RESET;
      amp_ctrl_r  <= REG_RESET;
      sw_ctrl_r   <= REG_RESET;
      ref_dac_r   <= REG_RESET;
      filt_ctrl_r <= REG_RESET;
    end else if (wr_go) begin
      case (paddr)
        OFS_GEN_CTRL:  gen_ctrl_r  <= pwdata[7:0] & MASK_GEN_CTRL;
        OFS_CLK_DIV:   clk_div_r   <= pwdata[7:0] & MASK_CLK_DIV;
        OFS_HALF_CNT:  half_cnt_r  <= pwdata[7:0] & MASK_HALF_CNT;
        OFS_AMP_CTRL:  amp_ctrl_r  <= pwdata[7:0] & MASK_AMP_CTRL;
        OFS_SW_CTRL:   sw_ctrl_r   <= pwdata[7:0] & MASK_SW_CTRL;
        OFS_REF_DAC:   ref_dac_r   <= pwdata[7:0] & MASK_REF_DAC;
        OFS_FILT_CTRL: filt_ctrl_r <= pwdata[7:0] & MASK_FILT;
        default:       gen_ctrl_r  <= gen_ctrl_r;
      endcase
    end
  end

  // ==========================================================================
  // pattern store, 32 x 9, one generated slot per sample
  generate
    for (genvar gi = 0; gi < PAT_ENTRIES; gi++) begin : g_pat
      always_ff @(posedge pclk) begin
        if (wr_go && is_pattern(paddr) && (pat_idx[5:1] == 5'(gi))) begin
          if (!pat_idx[0]) begin
            pat_mem[gi][7:0] <= pwdata[7:0];
          end else begin
            pat_mem[gi][8] <= pwdata[0];
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // sequencer: divide by N, step samples 0..DN-1
  assign half_len = 6'(half_cnt_r[4:0]) + 6'h01;
  assign last_idx = 6'({half_cnt_r[4:0], 1'b1});      // DN-1 = 2*HALF_CYCLE_SAMPLES-1
  assign tick     = (seq_r == SEQ_RUN) && (div_cnt_r == clk_div_r[5:0]);

  // run state follows the enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_r <= SEQ_IDLE;
    end else begin
      case (seq_r)
        SEQ_IDLE: seq_r <= gen_on ? SEQ_RUN : SEQ_IDLE;
        SEQ_RUN:  seq_r <= gen_on ? SEQ_RUN : SEQ_IDLE;
        default:  seq_r <= SEQ_IDLE;
      endcase
    end
  end

  // clock divider and sample counter, cleared while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 6'h00;
      sample_r  <= 6'h00;
    end else if (seq_r != SEQ_RUN || !gen_on) begin
      div_cnt_r <= 6'h00;
      sample_r  <= 6'h00;
    end else if (tick) begin
      div_cnt_r <= 6'h00;
      sample_r  <= (sample_r >= last_idx) ? 6'h00 : sample_r + 6'h01;
    end else begin
      div_cnt_r <= div_cnt_r + 6'h01;
    end
  end

  // fetch current sample; second half mirrored about mid-scale
  always_comb begin
    if (sample_r < half_len) begin
      cur_pat = pat_mem[sample_r[4:0]];
      dac_nxt = {1'b1, cur_pat};
    end else begin
      cur_pat = pat_mem[5'(sample_r - half_len)];
      dac_nxt = DAC_MID - {1'b0, cur_pat};
    end
  end

  // dac word register and period marker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_r    <= DAC_MID;
      period_r <= 1'b0;
    end else begin
      dac_r    <= (seq_r == SEQ_RUN) ? dac_nxt : DAC_MID;
      period_r <= (seq_r == SEQ_RUN) && (sample_r == 6'h00) && (div_cnt_r == 6'h00);
    end
  end

  // normalised gain select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_r <= GAIN_UNITY;
    end else begin
      gain_r <= gain_norm(amp_ctrl_r[3:0]);
    end
  end

  // ==========================================================================
  // outputs, all from flops
  assign pready       = pready_r;
  assign prdata       = prdata_r;
  assign pslverr      = pslverr_r;
  assign dac_code     = dac_r;
  assign period_start = period_r;

  // analog control bundle
  assign analog.gen_power           = gen_ctrl_r[GEN_EN_BIT];
  assign analog.bias_divider_enable = gen_ctrl_r[BIAS_EN_BIT];
  assign analog.amplifier_enable    = amp_ctrl_r[AMP_EN_BIT];
  assign analog.ref_dac_power       = amp_ctrl_r[AMP_EN_BIT];
  assign analog.diff_gain_select    = gain_r;
  assign analog.measure_switch_n    = sw_ctrl_r;
  assign analog.ref_dac_code        = ref_dac_r[5:0];
  assign analog.filter_enable       = filt_ctrl_r[FILT_EN_BIT];
  assign analog.hysteresis_enable   = filt_ctrl_r[HYST_EN_BIT];
  assign analog.discharge_switch_a  = filt_ctrl_r[DIS_A_BIT];
  assign analog.discharge_switch_b  = filt_ctrl_r[DIS_B_BIT];

  // ==========================================================================
  // checks: helper counters measure tick and period spacing
  logic [12:0] gap_r;
  logic [12:0] per_r;
  logic        seen_r;
  logic [12:0] m_len;
  assign m_len = 13'({7'h00, clk_div_r[5:0]} + 13'h1) * 13'({7'h00, half_len, 1'b0});

  // gap counts clocks since last tick, per since last period start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r  <= 13'h0000;
      per_r  <= 13'h0000;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= tick ? 13'h0001 : gap_r + 13'h0001;
      per_r  <= period_r ? 13'h0001 : per_r + 13'h0001;
      seen_r <= (seq_r == SEQ_RUN) && !wr_go && (seen_r || period_r);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_tick_spacing: assert property (tick && seen_r && !wr_go |-> gap_r == 13'(clk_div_r[5:0]) + 13'h1 || gap_r > 13'h40)
    else $error("sample step spacing differs from divider");
  chk_period_len: assert property (period_r && seen_r |-> per_r == m_len)
    else $error("output period length differs from N x DN");
  chk_idx_bound: assert property (seq_r == SEQ_RUN && !$past(wr_go) |-> sample_r <= last_idx)
    else $error("sample index beyond full cycle");
  chk_first_half: assert property (seq_r == SEQ_RUN && sample_r < half_len && !wr_go
                                   |=> dac_r == {1'b1, pat_mem[$past(sample_r[4:0])]})
    else $error("first half sample not taken from store");
  chk_mirror_half: assert property (seq_r == SEQ_RUN && sample_r >= half_len && !wr_go
                                    |=> dac_r[9] == 1'b0 || dac_r == DAC_MID)
    else $error("second half not mirrored below mid-scale");
  chk_disable_reset: assert property ($fell(gen_on) |=> ##1 sample_r == 6'h00 && div_cnt_r == 6'h00)
    else $error("counters not cleared after disable");
  chk_window_block: assert property (setup && is_pattern(paddr) && gen_on |=> pslverr_r && prdata_r == 32'h0)
    else $error("pattern window reachable while running");
  chk_reserved_zero: assert property (setup && is_ctrl(paddr) && !pwrite |=> prdata_r[31:8] == 24'h0)
    else $error("unimplemented bits read nonzero");
  chk_gain_fold: assert property (amp_ctrl_r[3:0] > GAIN_MAX_CODE |=> gain_r == GAIN_UNITY)
    else $error("invalid gain code not folded to unity");
  chk_amp_power: assert property (!amp_ctrl_r[AMP_EN_BIT] |-> !analog.ref_dac_power && !analog.amplifier_enable)
    else $error("amplifier path powered while disabled");
  // divider write lands masked in the next cycle
  chk_div_write: assert property (wr_go && paddr == OFS_CLK_DIV |=>
                                  clk_div_r == (8'($past(pwdata)) & MASK_CLK_DIV))
    else $error("divider write not masked");
  // half count write lands masked in the next cycle
  chk_count_write: assert property (wr_go && paddr == OFS_HALF_CNT |=>
                                    half_cnt_r == (8'($past(pwdata)) & MASK_HALF_CNT))
    else $error("half count write not masked");
  // enable and bias bits kept, other bits dropped
  chk_gen_write: assert property (wr_go && paddr == OFS_GEN_CTRL |=>
                                  gen_ctrl_r == (8'($past(pwdata)) & MASK_GEN_CTRL))
    else $error("generator control write not masked");
  // amplifier enable and raw gain code kept
  chk_amp_write: assert property (wr_go && paddr == OFS_AMP_CTRL |=>
                                  amp_ctrl_r == (8'($past(pwdata)) & MASK_AMP_CTRL))
    else $error("amplifier control write not masked");
  // every switch bit stored as written
  chk_sw_write: assert property (wr_go && paddr == OFS_SW_CTRL |=>
                                 sw_ctrl_r == 8'($past(pwdata)))
    else $error("switch control write lost");
  // reference code keeps bits 5:0 only
  chk_ref_write: assert property (wr_go && paddr == OFS_REF_DAC |=>
                                  ref_dac_r == (8'($past(pwdata)) & MASK_REF_DAC))
    else $error("reference code write not masked");
  // filter keeps enable, hysteresis and both discharge bits
  chk_filt_write: assert property (wr_go && paddr == OFS_FILT_CTRL |=>
                                   filt_ctrl_r == (8'($past(pwdata)) & MASK_FILT))
    else $error("filter control write not masked");
  // dac rests at mid-scale while the generator is off
  chk_dac_idle: assert property (seq_r != SEQ_RUN |=> dac_r == DAC_MID)
    else $error("dac not at mid-scale while idle");
  // each step moves the index by one inside a period
  chk_step_next: assert property (tick && gen_on && sample_r < last_idx |=>
                                  sample_r == $past(sample_r) + 6'h01)
    else $error("sample index did not advance by one");
  // last step of a period wraps to sample zero
  chk_wrap_zero: assert property (tick && gen_on && sample_r >= last_idx |=> sample_r == 6'h00)
    else $error("sample index did not wrap to zero");
  // period marker is a single-cycle pulse
  chk_period_pulse: assert property (period_r |=> !period_r)
    else $error("period marker longer than one cycle");
  // odd pattern word carries bit 8 alone
  chk_odd_read: assert property (setup && is_pattern(paddr) && !gen_on && !pwrite && pat_idx[0] |=>
                                 prdata_r[31:1] == 31'h0)
    else $error("odd pattern word reads extra bits");
  // valid gain codes pass through unchanged
  chk_gain_pass: assert property (amp_ctrl_r[3:0] != GAIN_UNITY && amp_ctrl_r[3:0] <= GAIN_MAX_CODE |=>
                                  gain_r == 4'($past(amp_ctrl_r)))
    else $error("valid gain code not passed");

  cov_period: cover property (period_r ##1 !period_r [*3] ##1 period_r);
  cov_blocked: cover property (setup && is_pattern(paddr) && gen_on);
  cov_restart: cover property ($fell(gen_on) ##[1:20] $rose(gen_on));
  cov_mirror: cover property (seq_r == SEQ_RUN && sample_r == half_len);
  cov_gain_fold: cover property (amp_ctrl_r[3:0] > GAIN_MAX_CODE);

endmodule
`default_nettype wire

/* File: sim/sds_analog_model.sv */
// analog front end model: watches the dac stream and the power controls
`timescale 1ns/10ps
`default_nettype none
module sds_analog_model
  import sds_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // stream and controls from the block
  input  wire logic [9:0]  dac_code,
  input  wire logic        period_start,
  input  wire sds_analog_s analog,
  // observations
  output logic      [15:0] period_cnt,
  output logic      [9:0]  sin_level
);
  // ==========================================================================
  // count output periods seen while the dac is powered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_cnt <= 16'h0000;
    end else if (period_start && analog.gen_power) begin
      period_cnt <= period_cnt + 16'h0001;
    end
  end
  // buffer amp follows the dac only while powered, else rests at mid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sin_level <= DAC_MID;
    end else begin
      sin_level <= analog.gen_power ? dac_code : DAC_MID;
    end
  end
endmodule
`default_nettype wire

/* File: sim/sds_sequencer_tb.sv */
// testbench: registers, refusals, gain table and sine stream of the sequencer
`timescale 1ns/10ps
`default_nettype none
module sds_sequencer_tb;
  import sds_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, period_start, er;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [9:0]        dac_code, sin_level;
  logic [15:0]       period_cnt, pc0;
  sds_analog_s       analog;
  int                fails, total_checks, cycles;
  logic [8:0]        pat [4] = '{9'h1F0, 9'h0A5, 9'h13C, 9'h001};
  logic [7:0]        msk [7] = '{8'h90, 8'h3F, 8'h1F, 8'h8F, 8'hFF, 8'h3F, 8'h93};
  logic [7:0]        sws [3] = '{8'hC1, 8'h32, 8'h0E};
  // ==========================================================================
  // clock, reset and hang guard
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end
  sds_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .dac_code(dac_code), .period_start(period_start), .analog(analog));
  sds_analog_model model_u (.pclk(pclk), .presetn(presetn), .dac_code(dac_code),
    .period_start(period_start), .analog(analog), .period_cnt(period_cnt), .sin_level(sin_level));
  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, experr});
  endtask
  // wait for a period pulse, both pulse and dac sampled at the same edge
  task automatic wait_ps();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (period_start !== 1'b1 && n < 200);
    chk({31'h0, period_start}, 32'h1);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 7; i++) rchk(12'(4 * i), 32'h0, 1'b0);
    chk(32'(analog), 32'h0);
    $display("reset values done");
  endtask
  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, 12'(4 * i), (i == 0) ? 32'hFFFF_FF7F : 32'hFFFF_FFFF);
      rchk(12'(4 * i), {24'h0, msk[i] & ((i == 0) ? 8'h7F : 8'hFF)}, 1'b0);
    end
    chk(32'(analog), {3'h0, 1'b0, 1'b1, 1'b1, 1'b1, 4'h0, 8'hFF, 6'h3F, 4'hF});
    apb(1'b1, OFS_AMP_CTRL, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk({30'h0, analog.amplifier_enable, analog.ref_dac_power}, 32'h0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFS_SW_CTRL, {24'h0, sws[i]});
      @(posedge pclk);
      chk({24'h0, analog.measure_switch_n}, {24'h0, sws[i]});
    end
    for (int i = 0; i < 7; i++) apb(1'b1, 12'(4 * i), 32'h0);
    $display("register fields done");
  endtask
  task automatic t_gain();
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, OFS_AMP_CTRL, 32'h80 | c);
      repeat (2) @(posedge pclk);
      chk({28'h0, analog.diff_gain_select}, (c >= 1 && c <= 10) ? c : 0);
    end
    $display("gain table done");
  endtask
  task automatic t_refuse();
    apb(1'b1, 12'h100, 32'h55);
    chk({31'h0, er}, 32'h1);
    rchk(12'h100, 32'h0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, PAT_BASE + 12'(8 * k), {23'h7FFFFF, pat[k]});
      apb(1'b1, PAT_BASE + 12'(8 * k + 4), {23'h7FFFFF, pat[k]} >> 8);
    end
    rchk(PAT_BASE + 12'h018, {24'h0, pat[3][7:0]}, 1'b0);
    rchk(PAT_BASE + 12'h004, {31'h0, pat[0][8]}, 1'b0);
    $display("refusals and pattern done");
  endtask
  task automatic t_stream();
    apb(1'b1, OFS_CLK_DIV, 32'h1);
    apb(1'b1, OFS_HALF_CNT, 32'h3);
    apb(1'b1, OFS_GEN_CTRL, 32'h80);
    wait_ps();
    pc0 = period_cnt;
    for (int k = 0; k < 8; k++) begin
      chk({22'h0, dac_code}, (k < 4) ? 32'h200 + pat[k] : 32'h200 - pat[k - 4]);
      repeat (2) @(posedge pclk);
    end
    chk({31'h0, period_start}, 32'h1);
    chk({22'h0, dac_code}, 32'h200 + pat[0]);
    apb(1'b1, PAT_BASE, 32'h0);
    chk({31'h0, er}, 32'h1);
    rchk(PAT_BASE, 32'h0, 1'b1);
    chk(32'(period_cnt - pc0) , 32'h2);
    apb(1'b1, OFS_GEN_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk({21'h0, analog.gen_power, dac_code}, 32'h200);
    chk({22'h0, sin_level}, 32'h200);
    rchk(PAT_BASE, {24'h0, pat[0][7:0]}, 1'b0);
    apb(1'b1, OFS_GEN_CTRL, 32'h80);
    wait_ps();
    chk({22'h0, dac_code}, 32'h200 + pat[0]);
    @(posedge pclk);
    chk({22'h0, sin_level}, 32'h200 + pat[0]);
    apb(1'b1, OFS_GEN_CTRL, 32'h0);
    $display("sine stream done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fails = 0;
    total_checks = 0;
    cycles = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_gain();
    t_refuse();
    t_stream();
    final_report();
  end
endmodule
`default_nettype wire
